// *** rtl/i2c_status_consts.vh ***
// constants for the two-wire status flag block
`ifndef I2C_STATUS_CONSTS_VH
`define I2C_STATUS_CONSTS_VH
// register word byte offsets
`define OFS_STATUS 4'h0
`define OFS_RECEIVE_HOLD 4'h4
`define OFS_TRANSMIT_HOLD 4'h8
`define OFS_IRQ_STATUS 4'hc
`define OFS_IRQ_MASK 4'h0
`define OFS_CONTROL 4'h0
// status field positions
`define BIT_TRANSMIT_FULL 0
`define BIT_RECEIVE_FULL 1
`define BIT_READ_WRITE 2
`define BIT_START_SEEN 3
`define BIT_STOP_SEEN 4
`define BIT_DATA_ADDR 5
// interrupt status and mask field positions
`define IRQ_RX_DONE 0
`define IRQ_TX_DONE 1
`define IRQ_STOP 2
`define IRQ_ADDR_MATCH 3
`define IRQ_WIDTH 4
// reset values
`define STATUS_RESET 6'h00
`define OWN_ADDR_RESET 7'h2a
`endif

// *** rtl/bus_edge_watch.v ***
// synchroniser and condition detector for the two bus lines
`timescale 1ns/1ps
module bus_edge_watch (
   // clock and control
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // raw bus lines
   input wire scl_i,
   input wire sda_i,
   // synchronised levels and events
   output reg scl_o,
   output reg sda_o,
   output reg scl_rise_o,
   output reg scl_fall_o,
   output reg start_o,
   output reg stop_o
);
   reg [1:0] scl_sync_ff;
   reg [1:0] sda_sync_ff;
   // ----------------------------------------------------------------
   // two stage synchronisers, then edge and condition decode
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         scl_o <= 1'b1;
         sda_o <= 1'b1;
         scl_rise_o <= 1'b0;
         scl_fall_o <= 1'b0;
         start_o <= 1'b0;
         stop_o <= 1'b0;
      end else if (ce_i) begin
         scl_sync_ff <= {scl_sync_ff[0], scl_i};
         sda_sync_ff <= {sda_sync_ff[0], sda_i};
         // only the second stage is looked at
         scl_o <= scl_sync_ff[1];
         sda_o <= sda_sync_ff[1];
         scl_rise_o <= scl_sync_ff[1] & ~scl_o;
         scl_fall_o <= ~scl_sync_ff[1] & scl_o;
         // data moving while clock high marks start or stop
         start_o <= scl_sync_ff[1] & scl_o & sda_o & ~sda_sync_ff[1];
         stop_o <= scl_sync_ff[1] & scl_o & ~sda_o & sda_sync_ff[1];
      end
   end
endmodule // bus_edge_watch

// *** rtl/i2c_status_flags.v ***
// two-wire slave with status flags behind a classic wishbone slave
// Contract
// RULE_01: address match clears, data byte sets data flag
// RULE_02: stop flag set only if stop last
// RULE_03: start flag set only if start last
// RULE_04: direction bit captured from address byte
// RULE_05: receive full set when byte loaded
// RULE_06: software read of receive register clears it
// RULE_07: software write of transmit register sets full
// RULE_08: transmit full clears when byte sent
// RULE_09: six status flags are read-only to software
`timescale 1ns/1ps
`include "i2c_status_consts.vh"
module i2c_status_flags (
   // clock, reset, enable
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // two-wire bus, open drain
   input wire scl_i,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_o,
   // interrupt
   output reg irq_o
);
   // ----------------------------------------------------------------
   // state codes of the serial engine
   // ----------------------------------------------------------------
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_ADDR_ACK = 3'd2;
   localparam ST_RX = 3'd3;
   localparam ST_RX_ACK = 3'd4;
   localparam ST_TX = 3'd5;
   localparam ST_TX_ACK = 3'd6;

   wire sda_s;
   wire scl_rise;
   wire scl_fall;
   wire start_ev;
   wire stop_ev;

   bus_edge_watch u_watch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .scl_o(),
      .sda_o(sda_s),
      .scl_rise_o(scl_rise),
      .scl_fall_o(scl_fall),
      .start_o(start_ev),
      .stop_o(stop_ev)
   );

   reg [2:0] state_ff;
   reg [2:0] bit_cnt_ff;
   reg [7:0] shift_ff;
   reg [7:0] receive_holding_reg_ff;
   reg [7:0] transmit_holding_reg_ff;
   reg [6:0] own_addr_ff;
   reg enable_ff;
   reg data_addr_ff;
   reg stop_seen_ff;
   reg start_seen_ff;
   reg read_write_ff;
   reg receive_full_flag_ff;
   reg transmit_full_flag_ff;
   reg [`IRQ_WIDTH-1:0] irq_stat_ff;
   reg [`IRQ_WIDTH-1:0] irq_mask_ff;
   reg nack_ff;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire bus_req = cyc_i & stb_i & ~ack_o;
   wire wr_req = bus_req & we_i;
   wire rd_req = bus_req & ~we_i;
   wire [3:0] ofs = {adr_i[3:2], 2'b00};
   // event strobes from the serial engine
   reg rx_load;
   reg tx_done;
   reg addr_hit;
   reg addr_dir;
   // software side effects
   wire rx_read = rd_req & (ofs == `OFS_RECEIVE_HOLD);
   wire tx_write = wr_req & (ofs == `OFS_TRANSMIT_HOLD) & sel_i[0];

   // ----------------------------------------------------------------
   // serial engine: slave receive and transmit
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 3'd0;
         shift_ff <= 8'h00;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         nack_ff <= 1'b0;
         rx_load <= 1'b0;
         tx_done <= 1'b0;
         addr_hit <= 1'b0;
         addr_dir <= 1'b0;
      end else if (ce_i) begin
         rx_load <= 1'b0;
         tx_done <= 1'b0;
         addr_hit <= 1'b0;
         sda_o <= 1'b0;
         if (!enable_ff || stop_ev) begin
            state_ff <= ST_IDLE;
            sda_oe_o <= 1'b0;
         end else if (start_ev) begin
            // repeated start restarts address reception
            state_ff <= ST_ADDR;
            bit_cnt_ff <= 3'd7;
            sda_oe_o <= 1'b0;
         end else begin
            case (state_ff)
               ST_IDLE: begin
                  sda_oe_o <= 1'b0;
               end
               ST_ADDR: begin
                  if (scl_rise) begin
                     shift_ff <= {shift_ff[6:0], sda_s};
                     bit_cnt_ff <= bit_cnt_ff - 3'd1;
                     if (bit_cnt_ff == 3'd0) begin
                        if (shift_ff[6:0] == own_addr_ff) begin
                           addr_hit <= 1'b1;
                           addr_dir <= sda_s;
                           state_ff <= ST_ADDR_ACK;
                        end else begin
                           state_ff <= ST_IDLE;
                        end
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  // drive ack low across the ninth clock
                  if (scl_fall && !sda_oe_o) begin
                     sda_oe_o <= 1'b1;
                  end else if (scl_fall && sda_oe_o) begin
                     bit_cnt_ff <= 3'd7;
                     if (read_write_ff) begin
                        state_ff <= ST_TX;
                        shift_ff <= transmit_holding_reg_ff;
                        sda_oe_o <= ~transmit_holding_reg_ff[7];
                     end else begin
                        state_ff <= ST_RX;
                        sda_oe_o <= 1'b0;
                     end
                  end else begin
                     sda_o <= 1'b0;
                  end
               end
               ST_RX: begin
                  if (scl_rise) begin
                     shift_ff <= {shift_ff[6:0], sda_s};
                     bit_cnt_ff <= bit_cnt_ff - 3'd1;
                     if (bit_cnt_ff == 3'd0) begin
                        rx_load <= 1'b1;
                        state_ff <= ST_RX_ACK;
                     end
                  end
               end
               ST_RX_ACK: begin
                  if (scl_fall && !sda_oe_o) begin
                     sda_oe_o <= 1'b1;
                  end else if (scl_fall && sda_oe_o) begin
                     sda_oe_o <= 1'b0;
                     bit_cnt_ff <= 3'd7;
                     state_ff <= ST_RX;
                  end
               end
               ST_TX: begin
                  // open drain: enable drives low for a zero bit
                  if (scl_fall) begin
                     bit_cnt_ff <= bit_cnt_ff - 3'd1;
                     if (bit_cnt_ff == 3'd0) begin
                        sda_oe_o <= 1'b0;
                        tx_done <= 1'b1;
                        state_ff <= ST_TX_ACK;
                     end else begin
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        sda_oe_o <= ~shift_ff[6];
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (scl_rise) begin
                     nack_ff <= sda_s;
                  end else if (scl_fall) begin
                     bit_cnt_ff <= 3'd7;
                     if (nack_ff) begin
                        state_ff <= ST_IDLE;
                     end else begin
                        state_ff <= ST_TX;
                        shift_ff <= transmit_holding_reg_ff;
                        sda_oe_o <= ~transmit_holding_reg_ff[7];
                     end
                  end
               end
               default: begin
                  state_ff <= ST_IDLE;
                  sda_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // status flags, hardware owned
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         data_addr_ff <= 1'b0;
         stop_seen_ff <= 1'b0;
         start_seen_ff <= 1'b0;
         read_write_ff <= 1'b0;
         receive_full_flag_ff <= 1'b0;
         transmit_full_flag_ff <= 1'b0;
         receive_holding_reg_ff <= 8'h00;
      end else if (ce_i) begin
         if (addr_hit) begin
            data_addr_ff <= 1'b0; // [RULE_01]
            read_write_ff <= addr_dir; // [RULE_04]
         end else if (rx_load) begin
            data_addr_ff <= 1'b1; // [RULE_01]
         end
         // whichever condition came last wins
         if (start_ev) begin
            start_seen_ff <= 1'b1; // [RULE_03]
            stop_seen_ff <= 1'b0; // [RULE_02]
         end else if (stop_ev) begin
            start_seen_ff <= 1'b0; // [RULE_03]
            stop_seen_ff <= 1'b1; // [RULE_02]
         end
         // load beats a same-cycle read so no byte is lost
         if (rx_load) begin
            receive_holding_reg_ff <= shift_ff; // byte already complete here
            receive_full_flag_ff <= 1'b1; // [RULE_05]
         end else if (rx_read) begin
            receive_full_flag_ff <= 1'b0; // [RULE_06]
         end
         if (tx_write) begin
            transmit_full_flag_ff <= 1'b1; // [RULE_07]
         end else if (tx_done) begin
            transmit_full_flag_ff <= 1'b0; // [RULE_08]
         end
      end
   end

   // ----------------------------------------------------------------
   // software registers: control, transmit data, interrupts
   // ----------------------------------------------------------------
   wire [`IRQ_WIDTH-1:0] irq_ev = {addr_hit, stop_ev, tx_done, rx_load};
   always @(posedge clk_i) begin
      if (rst_i) begin
         enable_ff <= 1'b0;
         own_addr_ff <= `OWN_ADDR_RESET;
         transmit_holding_reg_ff <= 8'h00;
         irq_stat_ff <= {`IRQ_WIDTH{1'b0}};
         irq_mask_ff <= {`IRQ_WIDTH{1'b0}};
      end else if (ce_i) begin
         if (tx_write) begin
            transmit_holding_reg_ff <= dat_i[7:0];
         end
         // status writes reach only the enable and own address: flags change only by hardware
         if (wr_req && ofs == `OFS_STATUS && sel_i[1]) begin
            enable_ff <= dat_i[15]; // [RULE_09]
         end
         if (wr_req && ofs == 4'h0 && sel_i[2]) begin
            own_addr_ff <= dat_i[22:16];
         end
         if (wr_req && ofs == `OFS_IRQ_STATUS && sel_i[0]) begin
            // new event wins over write-one-to-clear
            irq_stat_ff <= (irq_stat_ff & ~dat_i[`IRQ_WIDTH-1:0]) | irq_ev;
         end else begin
            irq_stat_ff <= irq_stat_ff | irq_ev;
         end
         if (wr_req && ofs == `OFS_IRQ_STATUS && sel_i[1]) begin
            irq_mask_ff <= dat_i[`IRQ_WIDTH+7:8];
         end
      end
   end

   // ----------------------------------------------------------------
   // read mux, ack and interrupt line
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         ack_o <= bus_req; // one wait state, unmapped reads give zero
         irq_o <= |(irq_stat_ff & irq_mask_ff);
         dat_o <= 32'h00000000;
         if (rd_req) begin
            case (ofs)
               `OFS_STATUS: dat_o <= {9'h000, own_addr_ff, enable_ff, 9'h000,
                  data_addr_ff, stop_seen_ff, start_seen_ff, read_write_ff,
                  receive_full_flag_ff, transmit_full_flag_ff};
               `OFS_RECEIVE_HOLD: dat_o <= {24'h000000, receive_holding_reg_ff};
               `OFS_TRANSMIT_HOLD: dat_o <= {24'h000000, transmit_holding_reg_ff};
               `OFS_IRQ_STATUS: dat_o <= {20'h00000, irq_mask_ff, 4'h0, irq_stat_ff};
               default: dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // i2c_status_flags

// *** bench/i2c_status_flags_properties.sv ***
// assertion checker for the two-wire status flag block
`timescale 1ns/1ps
module i2c_status_flags_checker (
   // clock and control
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // bus request
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   // bus answer
   input wire [31:0] dat_o,
   input wire ack_o,
   // link and interrupt
   input wire scl_i,
   input wire sda_i,
   input wire sda_o,
   input wire sda_oe_o,
   input wire irq_o
);
   logic scl_q_ff, sda_q_ff, quiet_ff;
   logic [2:0] still_ff = 3'h0;
   logic [1:0] cond_ff;
   logic [3:0] age_ff;
   logic [5:0] prev_ff;
   // bus cycle decodes
   wire st_rd = ack_o && !we_i && adr_i == 4'h0;
   wire st_req = cyc_i && stb_i && !we_i && adr_i == 4'h0;
   wire rx_rd = ack_o && !we_i && adr_i == 4'h4;
   wire tx_wr = ack_o && we_i && sel_i[0] && adr_i == 4'h8;
   wire buf_hit = ack_o && (adr_i == 4'h4 || adr_i == 4'h8);
   wire moved = scl_i != scl_q_ff || sda_i != sda_q_ff;
   wire cond = scl_i && scl_q_ff && moved;
   // last line condition and its age; quiet means no line move and no buffer access since a status read
   always @(posedge clk_i) begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
      if (st_rd) prev_ff <= dat_o[5:0];
      // a pin move takes a few cycles to reach the flags, so demand stillness first
      if (moved) still_ff <= 3'h0;
      else if (still_ff != 3'h7) still_ff <= still_ff + 3'h1;
      if (rst_i) quiet_ff <= 1'b0;
      else if (st_rd) quiet_ff <= (still_ff == 3'h7);
      else if (moved || buf_hit) quiet_ff <= 1'b0;
      // conditions seen while the enable is low never reach the flags
      if (rst_i) cond_ff <= 2'b00;
      else if (cond && ce_i) cond_ff <= {~sda_i, sda_i};
      if (rst_i || (cond && ce_i)) age_ff <= 4'h0;
      else if (age_ff != 4'hf) age_ff <= age_ff + 4'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_one_cycle: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_after_take: assert property (ce_i && cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered next cycle");
   a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data not zero while idle");
   a_sda_low_only: assert property (!sda_o)
      else $error("data line value not low");
   a_rx_clear_read: assert property (rx_rd ##1 !cyc_i ##1 st_req ##1 ack_o |-> !dat_o[1])
      else $error("receive full still set after read");
   a_tx_set_write: assert property (tx_wr ##1 !cyc_i ##1 st_req ##1 ack_o |-> dat_o[0])
      else $error("transmit full not set after write");
   a_flags_read_only: assert property (st_rd && quiet_ff |-> dat_o[5:0] == prev_ff)
      else $error("flags moved without an event");
   a_stop_last: assert property (st_rd && age_ff > 4'h7 && cond_ff != 2'b00 |-> dat_o[4] == cond_ff[0])
      else $error("stop flag wrong for last condition");
   a_start_last: assert property (st_rd && age_ff > 4'h7 && cond_ff != 2'b00 |-> dat_o[3] == cond_ff[1])
      else $error("start flag wrong for last condition");
endmodule // i2c_status_flags_checker
bind i2c_status_flags i2c_status_flags_checker chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i,
   .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .scl_i, .sda_i, .sda_o, .sda_oe_o, .irq_o);

// *** bench/two_wire_master.sv ***
// behavioural two-wire bus master on the link side
`timescale 1ns/1ps
module two_wire_master (
   // driven lines, data released when high
   output logic scl_o,
   output logic sda_o,
   // resolved data line
   input wire sda_i
);
   // clock stands high between frames
   initial {scl_o, sda_o} = 2'b11;
   // one quarter of the 400 ns bit period per step
   task automatic step(input logic c, input logic d);
      #100;
      scl_o = c;
      sda_o = d;
   endtask
   task automatic bit_cycle(input logic b, output logic r);
      step(1'b0, b);
      step(1'b1, b);
      #100;
      r = sda_i;
      step(1'b0, b);
   endtask
   // odd offset keeps line edges away from the sampling clock
   task automatic start_cond;
      #13;
      step(scl_o, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   task automatic stop_cond;
      #13;
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   task automatic byte_out(input logic [7:0] d, output logic nak);
      #13;
      for (int i = 7; i >= 0; i--) bit_cycle(d[i], nak);
      bit_cycle(1'b1, nak);
   endtask
   task automatic byte_in(input logic nak, output logic [7:0] d);
      logic r;
      #13;
      for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
      bit_cycle(nak, r);
   endtask
endmodule // two_wire_master

// *** bench/test_i2c_status_flags.sv ***
// self-checking bench for the two-wire status flag block
`timescale 1ns/1ps
module test_i2c_status_flags;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   wire [31:0] dat_o;
   wire ack_o, sda_o, sda_oe_o, irq_o, scl_w, sda_m;
   // open drain data line with pull-up
   wire sda_w = sda_m & ~sda_oe_o;
   logic [63:0] exp_q[$];
   logic [63:0] e_w;
   logic [7:0] rx_b, tx_b, got;
   logic nak;
   int err_total = 0, checks = 0, seed;
   i2c_status_flags uut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
      .dat_i, .dat_o, .ack_o, .scl_i(scl_w), .sda_i(sda_w), .sda_o, .sda_oe_o, .irq_o);
   two_wire_master bus (.scl_o(scl_w), .sda_o(sda_m), .sda_i(sda_w));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // one classic cycle; a read leaves masked data d as its expectation
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
      input logic [31:0] d, input logic [31:0] m);
      int n;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      if (!w) exp_q.push_back({m, d & m});
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         err_total++;
         tally_and_finish;
      end
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 4'hf, e, m);
   endtask
   // events need a few cycles through the synchronisers
   task automatic settle;
      repeat (10) @(posedge clk_i);
   endtask
   // watcher: every read answer takes the oldest note
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
         e_w = exp_q.pop_front();
         check("dat_o", dat_o & e_w[63:32], e_w[31:0]);
      end
   end
   initial begin
      seed = $urandom(12836);
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // reset values, then garbage over the flags with the enable set
      rd(4'h0, 32'hffffffff, 32'h002a0000);
      rd(4'hc, 32'hffffffff, 32'h0);
      wb(1'b1, 4'h0, 4'hf, {16'h002a, 10'h200, 6'($urandom)}, 32'h0);
      wb(1'b1, 4'hc, 4'h2, 32'h00000f00, 32'h0);
      rd(4'h0, 32'hffffffff, 32'h002a8000);
      $display("test reset_and_read_only done");
      // foreign address ignored, own address taken, one data byte in
      bus.start_cond();
      bus.byte_out(8'h56, nak);
      bus.stop_cond();
      settle;
      check("foreign nak", nak, 1'b1);
      bus.start_cond();
      bus.byte_out(8'h54, nak);
      settle;
      check("own ack", nak, 1'b0);
      rd(4'h0, 32'h3f, 32'h08);
      rx_b = 8'($urandom);
      bus.byte_out(rx_b, nak);
      settle;
      rd(4'h0, 32'h3f, 32'h2a);
      rd(4'h4, 32'hff, {24'h0, rx_b});
      rd(4'h0, 32'h3f, 32'h28);
      check("irq", irq_o, 1'b1);
      bus.stop_cond();
      settle;
      rd(4'h0, 32'h3f, 32'h30);
      rd(4'hc, 32'hfff, 32'hf0d);
      wb(1'b1, 4'hc, 4'h2, 32'h0, 32'h0);
      repeat (3) @(posedge clk_i);
      check("irq masked", irq_o, 1'b0);
      wb(1'b1, 4'hc, 4'h3, 32'h0f0f, 32'h0);
      rd(4'hc, 32'hfff, 32'hf00);
      $display("test write_transfer done");
      // byte handed back to a reading master
      tx_b = 8'($urandom);
      wb(1'b1, 4'h8, 4'h1, {24'h0, tx_b}, 32'h0);
      rd(4'h0, 32'h3f, 32'h31);
      bus.start_cond();
      bus.byte_out(8'h55, nak);
      settle;
      rd(4'h0, 32'h3f, 32'h0d);
      bus.byte_in(1'b1, got);
      bus.stop_cond();
      settle;
      check("sent byte", got, tx_b);
      rd(4'h0, 32'h1f, 32'h14);
      $display("test read_transfer done");
      // frozen enable: a start while stopped must leave the flags alone
      ce_i <= 1'b0;
      bus.start_cond();
      @(posedge clk_i);
      ce_i <= 1'b1;
      settle;
      rd(4'h0, 32'h18, 32'h10);
      check("pending notes", exp_q.size(), 32'h0);
      $display("test clock_enable done");
      tally_and_finish;
   end
endmodule // test_i2c_status_flags
